// *** ballast_phase_fault_supervisor.v ***
// phase sequencer and fault supervisor of the ballast controller, with axi4-lite registers
//
// Functional notes
// - Lamp sense above the upper threshold means no lamp: stop switching at once, go idle.
// - A rise above and fall below the upper threshold on lamp sense starts a new pre-heat, but not in the disable or board stop.
// - Pre-heat lasts exactly one timer cycle: charge to the high mark, discharge to the low.
// - Ignition lasts while the ignition ramp charges and ends at its completion threshold.
// - Run mode is kept until a fault is seen or supply is lost.
// - Lamp sense high at turn-on blocks the timer charge and keeps drivers stopped until low.
// - An end-of-life violation runs a timer cycle, reset if it clears, latching at its end.
// - In ignition a bridge current crossing runs a limited timer cycle, latching if it stays.
// - In run a low current crossing runs a timer cycle with frequency increase, then latches.
// - After a disable stop, bus monitor back above the release level restarts with pre-heat.
// - Bus over-voltage stops only the pfc driver until below the release level, no latch.
// - In run a high current crossing stops the drivers at once and latches idle.
// - Feedback open together with over-voltage stops all drivers, latched until lockout.
// - Bus monitor below the disable threshold shuts the drivers down at once, unlatched.
// - Run is entered when the ignition ramp is complete and the lamp has ignited.
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`include "ballast_defines.vh"

module ballast_phase_fault_supervisor #(
	parameter ADDR_W = 8
) (
	input wire clk_i,
	input wire srst_i,
	input wire ce_i,
	input wire supply_ok_i,
	input wire lamp_sense_high_i,
	input wire eol_window_fault_i,
	input wire bridge_low_i,
	input wire bridge_high_i,
	input wire bus_ovp_i,
	input wire bus_below_release_i,
	input wire bus_disable_i,
	input wire bus_enable_i,
	input wire feedback_open_i,
	input wire choke_saturation_i,
	input wire timer_high_i,
	input wire timer_low_i,
	input wire ignition_done_i,
	input wire lamp_ignited_i,
	output reg bridge_enable_o,
	output reg pfc_enable_o,
	output reg timer_charge_o,
	output reg ignition_ramp_run_o,
	output reg freq_increase_o,
	output reg low_power_o,
	output reg [3:0] phase_o,
	output reg irq_o,
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);

localparam NIN = 15;
localparam [3:0] ST_OFF = 4'h0;
localparam [3:0] ST_NO_LAMP = 4'h1;
localparam [3:0] ST_PREHEAT = 4'h2;
localparam [3:0] ST_IGNITE = 4'h3;
localparam [3:0] ST_RUN = 4'h4;
localparam [3:0] ST_LATCHED = 4'h5;
localparam [3:0] ST_DISABLED = 4'h6;
localparam [3:0] ST_BOARD = 4'h7;
localparam [1:0] TM_IDLE = 2'h0;
localparam [1:0] TM_CHARGE = 2'h1;
localparam [1:0] TM_DISCH = 2'h2;

////////////////////////////////////////////////////////////////////////////////
// input synchronisers

wire [NIN-1:0] pin_raw;
wire [NIN-1:0] pin_s;

assign pin_raw = {lamp_ignited_i, ignition_done_i, timer_low_i, timer_high_i,
	choke_saturation_i, feedback_open_i, bus_enable_i, bus_disable_i,
	bus_below_release_i, bus_ovp_i, bridge_high_i, bridge_low_i,
	eol_window_fault_i, lamp_sense_high_i, supply_ok_i};

genvar gi;
generate
	for (gi = 0; gi < NIN; gi = gi + 1) begin : g_sync
		reg meta;
		reg sync;
		always @(posedge clk_i) begin
			if (srst_i) begin
				meta <= 1'b0;
				sync <= 1'b0;
			end else if (ce_i) begin
				meta <= pin_raw[gi];
				sync <= meta;
			end
		end
		assign pin_s[gi] = sync;
	end
endgenerate

wire supply_ok = pin_s[0];
wire lamp_high = pin_s[1];
wire eol_fault = pin_s[2];
wire cur_low = pin_s[3];
wire cur_high = pin_s[4];
wire ovp = pin_s[5];
wire ovp_release = pin_s[6];
wire dis_low = pin_s[7];
wire dis_release = pin_s[8];
wire fb_open = pin_s[9];
wire choke_sat = pin_s[10];
wire tm_high = pin_s[11];
wire tm_low = pin_s[12];
wire ign_done = pin_s[13];
wire ignited = pin_s[14];

////////////////////////////////////////////////////////////////////////////////
// phase sequencer and fault timer

reg [3:0] state;
reg [1:0] tmr;
reg lamp_replacement_detect_seen;
reg ovp_flag;
reg [7:0] ctrl;
reg [3:0] next_state;
reg [1:0] next_tmr;
reg next_lamp_replacement_detect_seen;
reg next_ovp_flag;
reg fault_arm;
reg tmr_end;
wire run_en = ctrl[`BAL_CTRL_RUN_EN];
wire active = (state == ST_PREHEAT) || (state == ST_IGNITE) || (state == ST_RUN);

always @* begin
	next_state = state;
	next_tmr = tmr;
	next_lamp_replacement_detect_seen = lamp_replacement_detect_seen;
	next_ovp_flag = ovp_flag;
	tmr_end = (tmr == TM_DISCH) && tm_low;
	// guarded faults per phase
	case (state)
		ST_IGNITE: fault_arm = cur_high;
		ST_RUN: fault_arm = cur_low | eol_fault;
		default: fault_arm = 1'b0;
	endcase
	if (ovp)
		next_ovp_flag = 1'b1;
	else if (ovp_release)
		next_ovp_flag = 1'b0;
	// fault timer ramp
	case (tmr)
		TM_IDLE: if (state == ST_PREHEAT || fault_arm) next_tmr = TM_CHARGE;
		TM_CHARGE: if (tm_high) next_tmr = TM_DISCH;
		TM_DISCH: if (tm_low) next_tmr = TM_IDLE;
		default: next_tmr = TM_IDLE;
	endcase
	if (state == ST_RUN && !eol_fault && !cur_low)
		next_tmr = TM_IDLE;
	case (state)
		ST_OFF: begin
			if (supply_ok)
				next_state = lamp_high ? ST_NO_LAMP : ST_PREHEAT;
		end
		ST_NO_LAMP: begin
			if (!lamp_high)
				next_state = ST_PREHEAT;
		end
		ST_PREHEAT: begin
			if (tmr_end)
				next_state = ST_IGNITE;
		end
		ST_IGNITE: begin
			if (ign_done && ignited)
				next_state = ST_RUN;
			else if (tmr_end && cur_high)
				next_state = ST_LATCHED;
		end
		ST_RUN: begin
			if (cur_high)
				next_state = ST_LATCHED;
			else if (tmr_end && (eol_fault || cur_low))
				next_state = ST_LATCHED;
		end
		ST_LATCHED: begin
			if (lamp_high)
				next_lamp_replacement_detect_seen = 1'b1;
			else if (lamp_replacement_detect_seen)
				next_state = ST_PREHEAT;
		end
		ST_DISABLED: begin
			if (dis_release && !dis_low && run_en)
				next_state = ST_PREHEAT;
		end
		ST_BOARD: next_state = ST_BOARD;
		default: next_state = ST_OFF;
	endcase
	// board protection armed in every phase but off and board, disable and no-lamp only in pre-heat, ignition and run
	if (active || state == ST_LATCHED || state == ST_DISABLED || state == ST_NO_LAMP) begin
		if (fb_open && ovp)
			next_state = ST_BOARD;
		else if (active && (dis_low || !run_en))
			next_state = ST_DISABLED;
		else if (active && lamp_high)
			next_state = ST_NO_LAMP;
	end
	if (!supply_ok)
		next_state = ST_OFF;
	if (next_state != ST_LATCHED)
		next_lamp_replacement_detect_seen = 1'b0;
	if (next_state != ST_PREHEAT && next_state != ST_IGNITE && next_state != ST_RUN)
		next_tmr = TM_IDLE;
	else if (next_state != state)
		next_tmr = (next_state == ST_PREHEAT) ? TM_CHARGE : TM_IDLE;
end

wire next_active = (next_state == ST_PREHEAT) || (next_state == ST_IGNITE) ||
	(next_state == ST_RUN);

always @(posedge clk_i) begin
	if (srst_i) begin
		state <= ST_OFF;
		tmr <= TM_IDLE;
		lamp_replacement_detect_seen <= 1'b0;
		ovp_flag <= 1'b0;
		bridge_enable_o <= 1'b0;
		pfc_enable_o <= 1'b0;
		timer_charge_o <= 1'b0;
		ignition_ramp_run_o <= 1'b0;
		freq_increase_o <= 1'b0;
		low_power_o <= 1'b0;
		phase_o <= ST_OFF;
	end else if (ce_i) begin
		state <= next_state;
		tmr <= next_tmr;
		lamp_replacement_detect_seen <= next_lamp_replacement_detect_seen;
		ovp_flag <= next_ovp_flag;
		bridge_enable_o <= next_active;
		pfc_enable_o <= next_active && !next_ovp_flag && !choke_sat;
		timer_charge_o <= (next_tmr == TM_CHARGE);
		ignition_ramp_run_o <= (next_state == ST_IGNITE) || (next_state == ST_RUN);
		freq_increase_o <= ((next_state == ST_IGNITE) && cur_high) ||
			((next_state == ST_RUN) && cur_low);
		low_power_o <= !next_active && (next_state != ST_OFF);
		phase_o <= next_state;
	end
end

////////////////////////////////////////////////////////////////////////////////
// interrupt status and mask

reg [`BAL_IRQ_W-1:0] irq_stat;
reg [`BAL_IRQ_W-1:0] irq_mask;
reg [`BAL_IRQ_W-1:0] events;
reg [`BAL_IRQ_W-1:0] next_irq_stat;
wire rd_take = s_axi_arvalid && s_axi_arready;
wire [ADDR_W-1:0] rd_ofs = s_axi_araddr & {{(ADDR_W-2){1'b1}}, 2'b00};

always @* begin
	events = {`BAL_IRQ_W{1'b0}};
	if (next_state != state) begin
		events[`BAL_IRQ_RUN] = (next_state == ST_RUN);
		events[`BAL_IRQ_LAMP_OUT] = (next_state == ST_NO_LAMP);
		events[`BAL_IRQ_LATCH] = (next_state == ST_LATCHED);
		events[`BAL_IRQ_DISABLE] = (next_state == ST_DISABLED);
		events[`BAL_IRQ_BOARD] = (next_state == ST_BOARD);
	end
	events[`BAL_IRQ_OVP] = next_ovp_flag && !ovp_flag;
	next_irq_stat = irq_stat;
	if (rd_take && rd_ofs == `BAL_OFS_IRQ_STAT)
		next_irq_stat = {`BAL_IRQ_W{1'b0}};
	next_irq_stat = next_irq_stat | events;
end

////////////////////////////////////////////////////////////////////////////////
// axi4-lite slave

reg [ADDR_W-1:0] aw_addr;
reg aw_held;
reg [31:0] w_data;
reg [3:0] w_strb;
reg w_held;
wire [ADDR_W-1:0] wr_ofs = aw_addr & {{(ADDR_W-2){1'b1}}, 2'b00};
wire wr_go = aw_held && w_held && !s_axi_bvalid;
wire wr_map = (wr_ofs == `BAL_OFS_CTRL) || (wr_ofs == `BAL_OFS_STATUS) ||
	(wr_ofs == `BAL_OFS_IRQ_STAT) || (wr_ofs == `BAL_OFS_IRQ_MASK);
reg [31:0] rd_val;
reg rd_map;

always @* begin
	rd_val = 32'h0000_0000;
	rd_map = 1'b1;
	case (rd_ofs)
		`BAL_OFS_CTRL: rd_val[7:0] = ctrl;
		`BAL_OFS_STATUS: rd_val[8:0] = {ovp_flag, freq_increase_o, low_power_o,
			bridge_enable_o, pfc_enable_o, state};
		`BAL_OFS_IRQ_STAT: rd_val[`BAL_IRQ_W-1:0] = irq_stat;
		`BAL_OFS_IRQ_MASK: rd_val[`BAL_IRQ_W-1:0] = irq_mask;
		default: rd_map = 1'b0;
	endcase
end

always @(posedge clk_i) begin
	if (srst_i) begin
		aw_addr <= {ADDR_W{1'b0}};
		aw_held <= 1'b0;
		w_data <= 32'h0000_0000;
		w_strb <= 4'h0;
		w_held <= 1'b0;
		s_axi_awready <= 1'b0;
		s_axi_wready <= 1'b0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `BAL_RESP_OKAY;
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b0;
		s_axi_rresp <= `BAL_RESP_OKAY;
		s_axi_rdata <= 32'h0000_0000;
		ctrl <= `BAL_CTRL_RESET;
		irq_mask <= `BAL_IRQ_MASK_RESET;
		irq_stat <= {`BAL_IRQ_W{1'b0}};
		irq_o <= 1'b0;
	end else if (ce_i) begin
		// write address and data taken in either order
		s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
		s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
		if (s_axi_awvalid && s_axi_awready) begin
			aw_addr <= s_axi_awaddr;
			aw_held <= 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
			w_held <= 1'b1;
		end
		if (wr_go) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_map ? `BAL_RESP_OKAY : `BAL_RESP_SLVERR;
			if (w_strb[0] && wr_ofs == `BAL_OFS_CTRL)
				ctrl <= w_data[7:0];
			if (w_strb[0] && wr_ofs == `BAL_OFS_IRQ_MASK)
				irq_mask <= w_data[`BAL_IRQ_W-1:0];
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
		// read channel
		s_axi_arready <= !s_axi_rvalid && !rd_take;
		if (rd_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= rd_map ? `BAL_RESP_OKAY : `BAL_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
		irq_stat <= next_irq_stat;
		irq_o <= |(next_irq_stat & irq_mask);
	end
end

endmodule // ballast_phase_fault_supervisor

// *** ballast_defines.vh ***
// register map, field positions and reset values of the ballast supervisor
`ifndef BALLAST_DEFINES_VH
`define BALLAST_DEFINES_VH

// register byte offsets
`define BAL_OFS_CTRL 8'h00
`define BAL_OFS_STATUS 8'h04
`define BAL_OFS_IRQ_STAT 8'h08
`define BAL_OFS_IRQ_MASK 8'h0c

// control register fields
`define BAL_CTRL_RUN_EN 0
`define BAL_CTRL_RESET 8'h01

// status register fields
`define BAL_ST_PHASE_LSB 0
`define BAL_ST_PHASE_MSB 3
`define BAL_ST_PFC_EN 4
`define BAL_ST_BRIDGE_EN 5
`define BAL_ST_LOW_POWER 6
`define BAL_ST_FREQ_UP 7
`define BAL_ST_OVP 8

// interrupt event bits
`define BAL_IRQ_RUN 0
`define BAL_IRQ_LAMP_OUT 1
`define BAL_IRQ_LATCH 2
`define BAL_IRQ_DISABLE 3
`define BAL_IRQ_OVP 4
`define BAL_IRQ_BOARD 5
`define BAL_IRQ_W 6
`define BAL_IRQ_MASK_RESET 6'h00

// bus responses
`define BAL_RESP_OKAY 2'b00
`define BAL_RESP_SLVERR 2'b10

`endif

// *** ballast_props.sv ***
// assertions on the ballast supervisor ports
module ballast_props (
	input wire clk_i,
	input wire srst_i,
	input wire supply_ok_i,
	input wire lamp_sense_high_i,
	input wire bus_ovp_i,
	input wire bus_disable_i,
	input wire bridge_high_i,
	input wire feedback_open_i,
	input wire bridge_enable_o,
	input wire pfc_enable_o,
	input wire timer_charge_o,
	input wire ignition_ramp_run_o,
	input wire freq_increase_o,
	input wire low_power_o,
	input wire [3:0] phase_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	AST_LAMP: assert property (lamp_sense_high_i [*3] |=> !bridge_enable_o)
		else $error("bridge on without lamp");
	AST_IDLE: assert property (phase_o == 4'h1 |-> low_power_o && !bridge_enable_o
		&& !timer_charge_o) else $error("no-lamp idle broken");
	AST_PRE: assert property ($past(phase_o) == 4'h2 && phase_o == 4'h3
		|-> !$past(timer_charge_o)) else $error("ignite before discharge");
	AST_OVP: assert property (bus_ovp_i [*3] |=> !pfc_enable_o)
		else $error("pfc on in overvoltage");
	AST_DIS: assert property (bus_disable_i [*3] |=> !bridge_enable_o && !pfc_enable_o)
		else $error("drivers on while disabled");
	AST_HIGH: assert property ((bridge_high_i && phase_o == 4'h4) [*3] |=> phase_o != 4'h4)
		else $error("run kept on high current");
	AST_FREQ: assert property (freq_increase_o |-> phase_o == 4'h3 || phase_o == 4'h4)
		else $error("frequency raise out of phase");
	AST_RUN: assert property (phase_o == 4'h4 |-> bridge_enable_o && ignition_ramp_run_o)
		else $error("run without drive");
	AST_BOARD: assert property ((feedback_open_i && bus_ovp_i && supply_ok_i
		&& phase_o != 4'h0) [*3] |=> phase_o == 4'h7) else $error("no board latch");
	cover property (phase_o == 4'h4);
	cover property (phase_o == 4'h5);
	cover property (phase_o == 4'h7);
endmodule // ballast_props
bind ballast_phase_fault_supervisor ballast_props u_props (.*);

// *** ballast_analog_model.sv ***
// fault timer and ignition ramp comparators
module ballast_analog_model #(
	parameter int TC = 16,
	parameter int TI = 12
) (
	input wire logic clk_i,
	input wire logic charge_i,
	input wire logic ramp_run_i,
	output logic timer_high_o,
	output logic timer_low_o,
	output logic ignition_done_o
);
	timeunit 1ns;
	timeprecision 100ps;
	int tc = 0;
	int ti = 0;
	always @(posedge clk_i) begin
		if (charge_i && tc < TC)
			tc <= tc + 1;
		else if (!charge_i && tc > 0)
			tc <= tc - 1;
		ti <= ramp_run_i ? (ti < TI ? ti + 1 : ti) : 0;
	end
	assign timer_high_o = tc >= TC;
	assign timer_low_o = tc == 0;
	assign ignition_done_o = ti >= TI;
endmodule // ballast_analog_model

// *** test_ballast_phase_fault_supervisor.sv ***
// bench of the ballast supervisor
module test_ballast_phase_fault_supervisor;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 0, srst_i = 1, ce_i = 1, supply_ok_i = 0, lamp_sense_high_i = 0;
	logic eol_window_fault_i = 0, bridge_low_i = 0, bridge_high_i = 0, bus_ovp_i = 0;
	logic bus_below_release_i = 0, bus_disable_i = 0, bus_enable_i = 1, feedback_open_i = 0;
	logic choke_saturation_i = 0, lamp_ignited_i = 1, timer_high_i, timer_low_i;
	logic ignition_done_i, bridge_enable_o, pfc_enable_o, timer_charge_o, low_power_o;
	logic ignition_ramp_run_o, freq_increase_o, irq_o, s_axi_awready, s_axi_wready;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_bvalid;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_arready, s_axi_rvalid;
	logic [3:0] phase_o;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int miscompares = 0, n_tests = 0, cyc = 0;
	always #2.5 clk_i = ~clk_i;
	ballast_phase_fault_supervisor uut (.*);
	ballast_analog_model far (.clk_i(clk_i), .charge_i(timer_charge_o),
		.ramp_run_i(ignition_ramp_run_o), .timer_high_o(timer_high_i),
		.timer_low_o(timer_low_i), .ignition_done_o(ignition_done_i));
	////////////////////////////////////////
	task tally_and_finish;
		if (miscompares == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task go(input logic [3:0] p);
		int n;
		n = 0;
		while (phase_o !== p && n < 400) begin
			@(posedge clk_i);
			n++;
		end
		chk(phase_o, p);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge clk_i);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (s_axi_bvalid !== 1 && n < 50);
		s_axi_bready <= 0;
		chk(n < 50 ? s_axi_bresp : 2'bxx, e);
		@(posedge clk_i);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge clk_i);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (s_axi_rvalid !== 1 && n < 50);
		s_axi_rready <= 0;
		chk(n < 50 ? s_axi_rresp : 2'bxx, er);
		if (er === 2'b00) chk(s_axi_rdata, e);
		@(posedge clk_i);
	endtask
	task lamp_replacement_detect;
		lamp_sense_high_i <= 1;
		tick(8);
		chk({bridge_enable_o, low_power_o}, 2'b01);
		lamp_sense_high_i <= 0;
	endtask
	task torun;
		go(4'h2);
		go(4'h3);
		go(4'h4);
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 60000) begin
			miscompares++;
			tally_and_finish;
		end
	end
	////////////////////////////////////////
	initial begin
		tick(6);
		srst_i <= 0;
		tick(1);
		chk({phase_o, bridge_enable_o, pfc_enable_o, irq_o}, 32'h0);
		rd(8'h00, 32'h1, 2'b00);
		rd(8'h0c, 32'h0, 2'b00);
		rd(8'h10, 32'h0, 2'b10);
		wr(8'h10, 32'h1, 2'b10);
		wr(8'h04, 32'hff, 2'b00);
		rd(8'h04, 32'h0, 2'b00);
		wr(8'h0c, 32'h3f, 2'b00);
		lamp_sense_high_i <= 1;
		supply_ok_i <= 1;
		go(4'h1);
		tick(20);
		chk({timer_charge_o, bridge_enable_o}, 2'b00);
		lamp_sense_high_i <= 0;
		torun;
		chk(irq_o, 1'b1);
		rd(8'h08, 32'h3, 2'b00);
		rd(8'h08, 32'h0, 2'b00);
		chk(irq_o, 1'b0);
		wr(8'h0c, 32'h0, 2'b00);
		bus_ovp_i <= 1;
		tick(6);
		chk({pfc_enable_o, bridge_enable_o, irq_o}, 3'b010);
		bus_ovp_i <= 0;
		bus_below_release_i <= 1;
		tick(6);
		chk({pfc_enable_o, phase_o}, 5'h14);
		bus_below_release_i <= 0;
		wr(8'h0c, 32'h10, 2'b00);
		chk(irq_o, 1'b1);
		rd(8'h08, 32'h10, 2'b00);
		chk(irq_o, 1'b0);
		rd(8'h04, 32'h34, 2'b00);
		choke_saturation_i <= 1;
		tick(6);
		chk({pfc_enable_o, bridge_enable_o, ignition_ramp_run_o}, 3'b011);
		choke_saturation_i <= 0;
		tick(6);
		chk({pfc_enable_o, phase_o}, 5'h14);
		bridge_low_i <= 1;
		tick(6);
		chk(freq_increase_o, 1'b1);
		go(4'h5);
		bridge_low_i <= 0;
		lamp_replacement_detect;
		torun;
		eol_window_fault_i <= 1;
		tick(8);
		eol_window_fault_i <= 0;
		tick(60);
		chk(phase_o, 4'h4);
		eol_window_fault_i <= 1;
		go(4'h5);
		eol_window_fault_i <= 0;
		lamp_ignited_i <= 0;
		lamp_replacement_detect;
		go(4'h3);
		bridge_high_i <= 1;
		tick(6);
		chk(freq_increase_o, 1'b1);
		go(4'h5);
		bridge_high_i <= 0;
		lamp_ignited_i <= 1;
		lamp_replacement_detect;
		torun;
		bridge_high_i <= 1;
		tick(5);
		chk(phase_o, 4'h5);
		bridge_high_i <= 0;
		lamp_replacement_detect;
		go(4'h2);
		bridge_low_i <= 1;
		eol_window_fault_i <= 1;
		go(4'h3);
		chk(freq_increase_o, 1'b0);
		go(4'h4);
		bridge_low_i <= 0;
		eol_window_fault_i <= 0;
		tick(40);
		bus_disable_i <= 1;
		bus_enable_i <= 0;
		tick(5);
		chk({bridge_enable_o, pfc_enable_o, phase_o}, 6'h06);
		bus_disable_i <= 0;
		bus_enable_i <= 1;
		torun;
		wr(8'h00, 32'h0, 2'b00);
		go(4'h6);
		wr(8'h00, 32'h1, 2'b00);
		go(4'h2);
		feedback_open_i <= 1;
		bus_ovp_i <= 1;
		tick(5);
		chk(phase_o, 4'h7);
		feedback_open_i <= 0;
		bus_ovp_i <= 0;
		lamp_replacement_detect;
		chk(phase_o, 4'h7);
		supply_ok_i <= 0;
		go(4'h0);
		supply_ok_i <= 1;
		go(4'h2);
		rd(8'h08, 32'h3d, 2'b00);
		tally_and_finish;
	end
endmodule // test_ballast_phase_fault_supervisor
